// ===== src/wrg_cnt_if.sv
`timescale 1ns/1ns
interface wrg_cnt_if;
    logic       clear;
    logic       run;
    logic [2:0] period_sel;
    logic       overflow;

    modport ctrl (output clear, output run, output period_sel, input overflow);
    modport cnt  (input clear, input run, input period_sel, output overflow);
endinterface : wrg_cnt_if

// ===== src/wrg_osc_counter.sv
`timescale 1ns/1ns
`include "wrg_regs.svh"
module wrg_osc_counter import wrg_pkg::*; #(
    parameter int CNT_W = `WRG_CNT_W
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic slow_internal_osc,
    wrg_cnt_if.cnt    cnt_if
);

    logic             osc_meta_r;
    logic             osc_sync_r;
    logic             osc_prev_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] limit;
    wire              tick;
    wire              at_top;

    // overflow mask from the period select code
    function automatic logic [CNT_W-1:0] wrg_limit(input logic [2:0] sel);
        logic [4:0] bits;
        bits = 5'd8;
        case (sel)
            3'h0:    bits = 5'd8;
            3'h1:    bits = 5'd10;
            3'h2:    bits = 5'd12;
            3'h3:    bits = 5'd14;
            default: bits = 5'(sel) + 5'd11;
        endcase
        return {CNT_W{1'b1}} >> (CNT_W - int'(bits));
    endfunction : wrg_limit

    // two-stage sync of the slow oscillator, then edge detect
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= slow_internal_osc;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    // one count per slow oscillator rising edge
    assign tick            = osc_sync_r & ~osc_prev_r;
    assign limit           = wrg_limit(cnt_if.period_sel);
    assign at_top          = (count_r == limit);
    assign cnt_if.overflow = tick & cnt_if.run & at_top;

    always_comb begin
        count_nxt = count_r;
        if (cnt_if.clear || cnt_if.overflow) begin
            count_nxt = '0;
        end else if (tick && cnt_if.run) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_stopped_holds: assert property (!cnt_if.run && !cnt_if.clear |=> $stable(count_r))
        else $error("watchdog counter moved while disabled");
    chk_clear_zeroes: assert property (cnt_if.clear |=> count_r == '0)
        else $error("watchdog counter not cleared");

endmodule : wrg_osc_counter

// ===== src/wrg_pkg.sv
package wrg_pkg;

    typedef logic [7:0] wrg_byte_t;
    typedef logic [3:0] wrg_flags_t;

    // delayed reset sequencer
    typedef enum logic [0:0] {
        WRG_IDLE,
        WRG_DELAY
    } wrg_state_t;

endpackage : wrg_pkg

// ===== src/wrg_regs.svh
`ifndef WRG_REGS_SVH
`define WRG_REGS_SVH

// register offsets on the plain register port
`define WRG_ADDR_CTRL        2'h0
`define WRG_ADDR_FLAGS       2'h1
`define WRG_ADDR_GUARD       2'h2
`define WRG_ADDR_STATUS      2'h3

// watchdog control fields
`define WRG_EN_MSB           7
`define WRG_EN_LSB           3
`define WRG_SEL_MSB          2
`define WRG_SEL_LSB          0
`define WRG_EN_DISABLE       5'h15
`define WRG_EN_ENABLE        5'h0a
`define WRG_CTRL_RESET       8'h53

// reset guard codes
`define WRG_GUARD_OK_A       8'h55
`define WRG_GUARD_OK_B       8'haa
`define WRG_GUARD_RESET      8'h55

// reset cause flag bits
`define WRG_FLAG_WDREG       0
`define WRG_FLAG_VSEL        1
`define WRG_FLAG_LOWV        2
`define WRG_FLAG_GUARD       3
`define WRG_FLAGS_RESET      4'h0

// status bits
`define WRG_STAT_OVF         0
`define WRG_STAT_PDN         1

// delayed reset timing
`define WRG_CLK_PERIOD_NS    40
`define WRG_GUARD_DELAY_NS   1000
`define WRG_GUARD_DELAY_CYC  ((`WRG_GUARD_DELAY_NS + `WRG_CLK_PERIOD_NS - 1) / `WRG_CLK_PERIOD_NS)

// watchdog counter width for the longest period
`define WRG_CNT_W            18

`endif

// ===== src/wrg_top.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "wrg_regs.svh"
// What this block does
// - watchdog counter advances on the slow internal oscillator, not the system clock
// - period select 000..111 picks overflow at 2^8,10,12,14,15,16,17,18 ticks
// - enable code 10101 disables the watchdog, 01010 enables it
// - any other enable code resets the device after a fixed delay
// - that enable-code reset sets sticky flag bit 0
// - after power-on the control register reads 0x53
// - overflow in normal running gives full device reset and sets timeout flag
// - overflow in low-power mode sets timeout flag, resets only program counter and stack
// - counter clears on illegal enable code, clear instruction or halt
// - only the clear and halt instructions and an illegal enable code clear the counter from software
// - flag bit 0 is set by hardware only; software clears it writing 0
// - guard values 0x55 and 0xaa do nothing; others reset after the delay
// - after power-on the guard register holds 0x55
// - guard reset sets sticky flag bit 3, cleared by writing 0 or by power-on
// - flag bits 7..4 read zero; power-on clears flag bits 3..0
// - power-on zeroes program counter and sets all ports as inputs
// - entering low-power mode leaves the counter as is; halt clears it; it runs only if enabled
// - timeout flag sets on overflow, clears on power-up, clear or halt instruction
module wrg_top import wrg_pkg::*; #(
    parameter int DLY_CYC = `WRG_GUARD_DELAY_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       clear_instr,
    input  wire logic       halt_instr,
    input  wire logic       low_power_mode,
    input  wire logic       slow_internal_osc,
    input  wire logic       low_voltage_reset_event,
    input  wire logic       voltage_select_reg_reset_event,
    output logic            device_reset,
    output logic            pc_sp_reset,
    output logic            power_on_defaults
);

    localparam int DLY_USE = (DLY_CYC < 1) ? 1 : DLY_CYC;
    localparam int CHK_DLY_MAX = DLY_USE + 2;

    wrg_byte_t  ctrl_r;
    wrg_byte_t  guard_r;
    wrg_flags_t flags_r;
    wrg_flags_t flags_nxt;
    logic       ovf_seen_r;
    logic       pdn_r;
    wrg_byte_t  rdata_r;
    logic       dev_rst_r;
    logic       pcsp_rst_r;
    wrg_state_t state_r;
    logic [7:0] dly_cnt_r;
    logic       cause_en_r;
    logic       cause_guard_r;

    wrg_cnt_if cnt_if ();

    // register decode
    wire        wr_ctrl  = reg_wr & (reg_addr == `WRG_ADDR_CTRL);
    wire        wr_flags = reg_wr & (reg_addr == `WRG_ADDR_FLAGS);
    wire        wr_guard = reg_wr & (reg_addr == `WRG_ADDR_GUARD);
    wire  [4:0] en_code  = ctrl_r[`WRG_EN_MSB:`WRG_EN_LSB];

    // legality of the guarded codes
    wire        en_on       = (en_code == `WRG_EN_ENABLE);
    wire        en_off      = (en_code == `WRG_EN_DISABLE);
    wire        illegal_en  = ~en_on & ~en_off;
    wire        illegal_grd = (guard_r != `WRG_GUARD_OK_A)
                            & (guard_r != `WRG_GUARD_OK_B);

    // delayed reset sequencing
    wire        start_dly   = (state_r == WRG_IDLE) & (illegal_en | illegal_grd);
    wire        start_en    = start_dly & illegal_en;
    wire        dly_fire    = (state_r == WRG_DELAY) & (dly_cnt_r == 8'h00);
    wire        fire_en     = dly_fire & (cause_en_r | illegal_en);
    wire        fire_guard  = dly_fire & (cause_guard_r | illegal_grd);

    // watchdog overflow routing
    wire        ovf         = cnt_if.overflow;
    wire        ovf_full    = ovf & ~low_power_mode;
    wire        ovf_sleep   = ovf & low_power_mode;
    wire        full_rst    = dly_fire | ovf_full;

    // counter controls
    assign cnt_if.run        = en_on;
    assign cnt_if.period_sel = ctrl_r[`WRG_SEL_MSB:`WRG_SEL_LSB];
    assign cnt_if.clear      = start_en | clear_instr | halt_instr | dev_rst_r;

    wrg_osc_counter #(
        .CNT_W (`WRG_CNT_W)
    ) u_counter (
        .clk               (clk),
        .reset             (reset),
        .slow_internal_osc (slow_internal_osc),
        .cnt_if            (cnt_if)
    );

    // flags: hardware set wins over software clear
    wire  [3:0] flag_clr = wr_flags ? ~reg_wdata[3:0] : 4'h0;
    wire  [3:0] flag_set = {fire_guard, low_voltage_reset_event,
                            voltage_select_reg_reset_event, fire_en};
    assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

    // read selection
    wire  [7:0] rd_mux = (reg_addr == `WRG_ADDR_CTRL)  ? ctrl_r :
                         (reg_addr == `WRG_ADDR_FLAGS) ? {4'h0, flags_r} :
                         (reg_addr == `WRG_ADDR_GUARD) ? guard_r :
                         {6'h00, pdn_r, ovf_seen_r};

    // control and guard registers, reloaded by any full reset
    always_ff @(posedge clk) begin
        if (reset || full_rst) begin
            ctrl_r  <= `WRG_CTRL_RESET;
            guard_r <= `WRG_GUARD_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata;
            end
            if (wr_guard) begin
                guard_r <= reg_wdata;
            end
        end
    end

    // sticky reset cause flags
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_r <= `WRG_FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // timeout and power-down status
    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_seen_r <= 1'b0;
            pdn_r      <= 1'b0;
        end else begin
            if (ovf) begin
                ovf_seen_r <= 1'b1;
            end else if (clear_instr || halt_instr) begin
                ovf_seen_r <= 1'b0;
            end
            if (halt_instr) begin
                pdn_r <= 1'b1;
            end else if (clear_instr) begin
                pdn_r <= 1'b0;
            end
        end
    end

    // delay sequencer for guarded-code resets
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r       <= WRG_IDLE;
            dly_cnt_r     <= 8'h00;
            cause_en_r    <= 1'b0;
            cause_guard_r <= 1'b0;
        end else begin
            case (state_r)
                WRG_IDLE: begin
                    if (start_dly && !ovf_full) begin
                        state_r       <= WRG_DELAY;
                        dly_cnt_r     <= 8'(DLY_USE - 1);
                        cause_en_r    <= illegal_en;
                        cause_guard_r <= illegal_grd;
                    end
                end
                WRG_DELAY: begin
                    if (full_rst) begin
                        state_r       <= WRG_IDLE;
                        cause_en_r    <= 1'b0;
                        cause_guard_r <= 1'b0;
                    end else begin
                        dly_cnt_r     <= dly_cnt_r - 8'h01;
                        cause_en_r    <= cause_en_r | illegal_en;
                        cause_guard_r <= cause_guard_r | illegal_grd;
                    end
                end
                default: begin
                    state_r <= WRG_IDLE;
                end
            endcase
        end
    end

    // reset pulses and read data
    always_ff @(posedge clk) begin
        if (reset) begin
            dev_rst_r  <= 1'b0;
            pcsp_rst_r <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            dev_rst_r  <= full_rst;
            pcsp_rst_r <= ovf_sleep;
            rdata_r    <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata         = rdata_r;
    assign device_reset      = dev_rst_r;
    assign pc_sp_reset       = pcsp_rst_r;
    assign power_on_defaults = reset;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_ctrl_por_value: assert property ($fell(reset) |-> ctrl_r == `WRG_CTRL_RESET)
        else $error("control register not 0x53 after reset");
    chk_guard_por_value: assert property ($fell(reset) |-> guard_r == `WRG_GUARD_RESET)
        else $error("guard register not 0x55 after reset");
    chk_en_delay_reset: assert property (start_en && !ovf_full
        |-> ##[1:CHK_DLY_MAX] (dev_rst_r && flags_r[`WRG_FLAG_WDREG]))
        else $error("illegal enable code did not reset and flag");
    chk_guard_delay_rst: assert property (start_dly && illegal_grd && !ovf_full
        |-> ##[1:CHK_DLY_MAX] (dev_rst_r && flags_r[`WRG_FLAG_GUARD]))
        else $error("illegal guard value did not reset and flag");
    chk_flag_sticky: assert property (flags_r[`WRG_FLAG_WDREG]
        && !(wr_flags && !reg_wdata[`WRG_FLAG_WDREG]) |=> flags_r[`WRG_FLAG_WDREG])
        else $error("watchdog register flag lost without clear");
    chk_flag_no_swset: assert property (!flags_r[`WRG_FLAG_WDREG] && !fire_en
        |=> !flags_r[`WRG_FLAG_WDREG])
        else $error("watchdog register flag set without cause");
    chk_ovf_full_reset: assert property (ovf_full |=> dev_rst_r && ovf_seen_r && !pcsp_rst_r)
        else $error("normal overflow did not give full reset");
    chk_ovf_sleep_part: assert property (ovf_sleep && !dly_fire
        |=> pcsp_rst_r && ovf_seen_r && !dev_rst_r)
        else $error("low-power overflow reset wrong");
    chk_clear_timeout: assert property (clear_instr && !ovf |=> !ovf_seen_r)
        else $error("clear instruction left timeout flag");
    chk_rsvd_read_zero: assert property (reg_rd && reg_addr == `WRG_ADDR_FLAGS
        |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved flag bits read nonzero");
    chk_disable_no_run: assert property (en_off |-> !cnt_if.run)
        else $error("watchdog running with disable code");
    chk_lowv_capture: assert property (low_voltage_reset_event |=> flags_r[`WRG_FLAG_LOWV])
        else $error("low-voltage event not captured");

    cov_ovf_normal: cover property (ovf_full);
    cov_ovf_sleep: cover property (ovf_sleep);
    cov_en_fire: cover property (fire_en);
    cov_guard_fire: cover property (fire_guard);

endmodule : wrg_top

// ===== testbench/test_wrg_top.sv
`timescale 1ns/1ns
`include "wrg_regs.svh"
module test_wrg_top import wrg_pkg::*; ;
    localparam int DLY  = 2;
    localparam int CEIL = 40000;

    logic       clk;
    logic       reset;
    logic [1:0] reg_addr;
    wrg_byte_t  reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    wrg_byte_t  reg_rdata;
    logic       clear_instr;
    logic       halt_instr;
    logic       low_power_mode;
    logic       slow_internal_osc;
    logic       low_voltage_reset_event;
    logic       voltage_select_reg_reset_event;
    logic       device_reset;
    logic       pc_sp_reset;
    logic       power_on_defaults;
    logic       rd_seen;
    int         n_mismatch;
    int         n_tests;
    int         n_dev;
    int         n_pcsp;
    int         fire_at;
    int         osc_cnt;
    int         k;
    integer     seed;
    wrg_byte_t  v;
    wrg_byte_t  exp_q[$];

    wrg_top #(.DLY_CYC(DLY)) i_dut (
        .clk                            (clk),
        .reset                          (reset),
        .reg_addr                       (reg_addr),
        .reg_wdata                      (reg_wdata),
        .reg_wr                         (reg_wr),
        .reg_rd                         (reg_rd),
        .reg_rdata                      (reg_rdata),
        .clear_instr                    (clear_instr),
        .halt_instr                     (halt_instr),
        .low_power_mode                 (low_power_mode),
        .slow_internal_osc              (slow_internal_osc),
        .low_voltage_reset_event        (low_voltage_reset_event),
        .voltage_select_reg_reset_event (voltage_select_reg_reset_event),
        .device_reset                   (device_reset),
        .pc_sp_reset                    (pc_sp_reset),
        .power_on_defaults              (power_on_defaults)
    );

    // system clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, expv, seen);
        end
    endtask : check

    task close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // one-cycle register write
    task wr(input logic [1:0] a, input wrg_byte_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // one-cycle register read, expected data noted for the monitor
    task rd(input logic [1:0] a, input wrg_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask : rd

    // one-cycle clear or halt instruction
    task instr(input bit halt);
        @(posedge clk);
        if (halt) halt_instr <= 1'b1;
        else clear_instr <= 1'b1;
        @(posedge clk);
        halt_instr  <= 1'b0;
        clear_instr <= 1'b0;
    endtask : instr

    // slow oscillator edges, four system clocks per period
    task osc_run(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk);
            slow_internal_osc <= 1'b1;
            osc_cnt++;
            repeat (2) @(posedge clk);
            slow_internal_osc <= 1'b0;
        end
    endtask : osc_run

    // cycles from the end of a write until the delayed reset pulse
    task wait_fire(output int cnt);
        cnt = 0;
        for (int i = 1; i <= 50; i++) begin
            @(negedge clk);
            if (device_reset === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask : wait_fire

    // read data monitor, compares the oldest note
    always @(posedge clk) rd_seen <= reg_rd & ~reset;
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check("read note", 32'h1, 32'h0);
            else check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end

    // reset pulse monitor, records the osc edge count of each pulse
    always @(negedge clk) begin
        if (device_reset === 1'b1) begin
            n_dev++;
            fire_at = osc_cnt;
        end
        if (pc_sp_reset === 1'b1) begin
            n_pcsp++;
            fire_at = osc_cnt;
        end
    end

    // hang guard
    initial begin
        repeat (CEIL) @(posedge clk);
        n_mismatch++;
        $display("timeout after %0d cycles", CEIL);
        close_out();
    end

    initial begin
        seed = 32'ha1d1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, clear_instr, halt_instr} = '0;
        {low_power_mode, slow_internal_osc, low_voltage_reset_event} = '0;
        voltage_select_reg_reset_event = 1'b0;
        reset = 1'b1;
        {n_mismatch, n_tests, n_dev, n_pcsp, fire_at, osc_cnt} = '0;
        repeat (11) @(posedge clk);
        @(negedge clk);
        check("power_on_defaults", power_on_defaults, 1);
        @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check("power_on_defaults", power_on_defaults, 0);
        rd(`WRG_ADDR_CTRL, `WRG_CTRL_RESET);
        rd(`WRG_ADDR_GUARD, `WRG_GUARD_RESET);
        rd(`WRG_ADDR_FLAGS, 8'h00);
        rd(`WRG_ADDR_STATUS, 8'h00);
        $display("test reset values done");
        // plain accesses, no reset expected
        v = {`WRG_EN_DISABLE, 3'($random(seed))};
        wr(`WRG_ADDR_CTRL, v);
        rd(`WRG_ADDR_CTRL, v);
        wr(`WRG_ADDR_FLAGS, 8'hff);
        rd(`WRG_ADDR_FLAGS, 8'h00);
        wr(`WRG_ADDR_GUARD, `WRG_GUARD_OK_B);
        rd(`WRG_ADDR_GUARD, `WRG_GUARD_OK_B);
        wr(`WRG_ADDR_STATUS, 8'hff);
        rd(`WRG_ADDR_STATUS, 8'h00);
        repeat (10) @(posedge clk);
        check("device_reset count", n_dev, 0);
        $display("test register access done");
        // illegal enable code
        do v = 8'($random(seed)); while (v[7:3] == `WRG_EN_ENABLE || v[7:3] == `WRG_EN_DISABLE);
        wr(`WRG_ADDR_CTRL, v);
        wait_fire(k);
        check("enable code reset delay", k, DLY + 2);
        rd(`WRG_ADDR_FLAGS, 8'h01);
        rd(`WRG_ADDR_CTRL, `WRG_CTRL_RESET);
        wr(`WRG_ADDR_FLAGS, 8'h00);
        rd(`WRG_ADDR_FLAGS, 8'h00);
        $display("test illegal enable code done");
        // illegal guard value
        do v = 8'($random(seed)); while (v == `WRG_GUARD_OK_A || v == `WRG_GUARD_OK_B);
        wr(`WRG_ADDR_GUARD, v);
        wait_fire(k);
        check("guard reset delay", k, DLY + 2);
        rd(`WRG_ADDR_FLAGS, 8'h08);
        rd(`WRG_ADDR_GUARD, `WRG_GUARD_RESET);
        wr(`WRG_ADDR_FLAGS, 8'h00);
        rd(`WRG_ADDR_FLAGS, 8'h00);
        $display("test illegal guard value done");
        // external reset events
        @(posedge clk);
        low_voltage_reset_event        <= 1'b1;
        voltage_select_reg_reset_event <= 1'b1;
        @(posedge clk);
        low_voltage_reset_event        <= 1'b0;
        voltage_select_reg_reset_event <= 1'b0;
        rd(`WRG_ADDR_FLAGS, 8'h06);
        wr(`WRG_ADDR_FLAGS, 8'h04);
        rd(`WRG_ADDR_FLAGS, 8'h04);
        wr(`WRG_ADDR_FLAGS, 8'h00);
        $display("test reset events done");
        // disabled watchdog, then overflow in normal running
        wr(`WRG_ADDR_CTRL, {`WRG_EN_DISABLE, 3'b000});
        n_dev = 0;
        osc_run(300);
        check("disabled overflow count", n_dev, 0);
        wr(`WRG_ADDR_CTRL, {`WRG_EN_ENABLE, 3'b000});
        instr(0);
        repeat (300) @(posedge clk);
        check("count without osc", n_dev, 0);
        osc_run(200);
        instr(0);
        osc_cnt = 0;
        osc_run(260);
        check("full reset count", n_dev, 1);
        check("overflow edge 2^8", fire_at, 256);
        rd(`WRG_ADDR_STATUS, 8'h01);
        instr(1);
        rd(`WRG_ADDR_STATUS, 8'h02);
        $display("test normal overflow done");
        // overflow in low-power mode, halt clears the count
        low_power_mode <= 1'b1;
        wr(`WRG_ADDR_CTRL, {`WRG_EN_ENABLE, 3'b001});
        {n_dev, n_pcsp} = '0;
        osc_run(600);
        instr(1);
        osc_cnt = 0;
        osc_run(1030);
        check("pc_sp reset count", n_pcsp, 1);
        check("full reset count", n_dev, 0);
        check("overflow edge 2^10", fire_at, 1024);
        rd(`WRG_ADDR_STATUS, 8'h03);
        rd(`WRG_ADDR_CTRL, {`WRG_EN_ENABLE, 3'b001});
        instr(0);
        rd(`WRG_ADDR_STATUS, 8'h00);
        low_power_mode <= 1'b0;
        $display("test low-power overflow done");
        // longer period in normal running
        wr(`WRG_ADDR_CTRL, {`WRG_EN_ENABLE, 3'b010});
        instr(0);
        {n_dev, osc_cnt} = '0;
        osc_run(4100);
        check("full reset count", n_dev, 1);
        check("overflow edge 2^12", fire_at, 4096);
        rd(`WRG_ADDR_STATUS, 8'h01);
        $display("test long period done");
        // second power-on reset in mid-run
        @(posedge clk);
        low_voltage_reset_event <= 1'b1;
        @(posedge clk);
        low_voltage_reset_event <= 1'b0;
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(`WRG_ADDR_FLAGS, 8'h00);
        rd(`WRG_ADDR_CTRL, `WRG_CTRL_RESET);
        rd(`WRG_ADDR_STATUS, 8'h00);
        repeat (3) @(posedge clk);
        $display("test second reset done");
        close_out();
    end
endmodule : test_wrg_top
